//--- plc_cond_pkg.sv
// constants, register map and helpers for input conditioning
package plc_cond_pkg;
  localparam int CLK_NS = 50;
  localparam int TICK_NS = 50000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int WORD_W = 12;
  localparam int KNOB_W = 8;
  localparam int NPIN = 4;
  localparam int PIN_LO = 3;
  localparam int FCNT_W = 12;
  localparam int ADDR_W = 12;
  localparam logic [FCNT_W-1:0] TICKS_PER_MS = 12'h014;
  localparam logic [7:0] KNOB_MAX = 8'hC8;
  localparam logic [NPIN-1:0] PINS_SMALL = 4'h3;
  localparam logic [NPIN-1:0] PINS_LARGE = 4'hF;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h000;
  localparam logic [9:0] IDX_IN0 = 10'h001;
  localparam logic [9:0] IDX_IN1 = 10'h002;
  localparam logic [9:0] IDX_QR = 10'h003;
  localparam logic [9:0] IDX_SET0 = 10'h004;
  localparam logic [9:0] IDX_SET1 = 10'h005;
  localparam logic [9:0] IDX_SET2 = 10'h006;
  localparam logic [9:0] IDX_SET3 = 10'h007;
  localparam logic [9:0] IDX_KNOB0 = 10'h0FA;
  localparam logic [9:0] IDX_KNOB1 = 10'h0FB;
  localparam int CTRL_SEL_LO = 0;
  localparam int CTRL_MODE_LO = 8;
  localparam logic [15:0] CTRL_MASK = 16'hFF07;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  typedef enum logic [1:0] {
    MODE_PLAIN, MODE_INT, MODE_CNT, MODE_QR
  } pin_mode_t;

  // word 001+ settle limits in 50 us ticks, inside the faster window
  function automatic logic [FCNT_W-1:0] fast_limit(input logic [2:0] sel);
    case (sel)
      3'h0: fast_limit = 12'h004;
      3'h1: fast_limit = 12'h014;
      3'h2: fast_limit = 12'h028;
      3'h3: fast_limit = 12'h046;
      3'h4: fast_limit = 12'h08C;
      3'h5: fast_limit = 12'h118;
      3'h6: fast_limit = 12'h230;
      default: fast_limit = 12'h4B0;
    endcase
  endfunction : fast_limit

  // clamp to the top of the knob range and convert to three bcd digits
  function automatic logic [15:0] to_bcd(input logic [7:0] v);
    logic [7:0] c;
    logic [7:0] h;
    logic [7:0] r;
    c = (v > KNOB_MAX) ? KNOB_MAX : v;
    h = c / 8'h64;
    r = c % 8'h64;
    to_bcd = {4'h0, h[3:0], 4'((r / 8'h0A)), 4'((r % 8'h0A))};
  endfunction : to_bcd
endpackage : plc_cond_pkg

//--- plc_input_conditioning.sv
// input filter, interrupt/counter/quick-response pins and knob words
//
// Added by the designer: the APB register port.
module plc_input_conditioning #(
  parameter int TICK_CYCLES = plc_cond_pkg::TICK_CYC
) (
  input wire logic pclk, // 20 MHz bus clock
  input wire logic presetn, // async reset, active low
  input wire logic [11:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  input wire logic [11:0] in_w0, // raw terminals of word 000
  input wire logic [11:0] in_w1, // raw terminals of word 001
  input wire logic [7:0] knob0_raw, // knob zero converter value
  input wire logic [7:0] knob1_raw, // knob one converter value
  input wire logic wide_unit, // high on units above ten terminals
  output logic [3:0] int_req // one-cycle service request per pin
);
  localparam int WW = plc_cond_pkg::WORD_W;
  localparam int KW = plc_cond_pkg::KNOB_W;
  localparam int NP = plc_cond_pkg::NPIN;
  localparam int FW = plc_cond_pkg::FCNT_W;
  localparam int NF = 2 * WW;
  localparam int NS = NF + 2 * KW + 1;

  // three-stage synchroniser; a bit moves once stages two and three agree
  logic [NS-1:0] s1_r, s2_r, s3_r, acc_r, acc_nxt;
  always_comb begin
    acc_nxt = (s2_r & s3_r) | (acc_r & (s2_r ^ s3_r));
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      acc_r <= '0;
    end else begin
      s1_r <= {wide_unit, knob1_raw, knob0_raw, in_w1, in_w0};
      s2_r <= s1_r;
      s3_r <= s2_r;
      acc_r <= acc_nxt;
    end
  end

  logic [NF-1:0] raw;
  logic wide;
  logic [NP-1:0] pin_act, pin_raw;
  assign raw = acc_r[NF-1:0];
  assign wide = acc_r[NS-1];
  assign pin_raw = raw[plc_cond_pkg::PIN_LO +: NP];
  assign pin_act = wide ? plc_cond_pkg::PINS_LARGE
                        : plc_cond_pkg::PINS_SMALL;

  // 50 us base tick shared by all filters
  logic [15:0] tick_r, tick_nxt;
  logic tick;
  assign tick = (tick_r == 16'(TICK_CYCLES - 1));
  always_comb begin
    tick_nxt = tick ? 16'h0000 : tick_r + 16'h0001;
  end

  // register bank
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] set_r [NP];
  logic [15:0] set_nxt [NP];
  logic [2:0] sel;
  assign sel = ctrl_r[plc_cond_pkg::CTRL_SEL_LO +: 3];

  // per-bit filter: settle counter runs while raw differs from output
  logic [FW-1:0] fcnt_r [NF];
  logic [FW-1:0] fcnt_nxt [NF];
  logic [NF-1:0] filt_r, filt_nxt;
  logic [FW-1:0] lim_slow, lim_fast;
  always_comb begin
    lim_slow = plc_cond_pkg::TICKS_PER_MS << sel;
    lim_fast = plc_cond_pkg::fast_limit(sel);
    filt_nxt = filt_r;
    for (int i = 0; i < NF; i++) begin
      fcnt_nxt[i] = fcnt_r[i];
      if (raw[i] == filt_r[i]) begin
        fcnt_nxt[i] = '0;
      end else if (tick) begin
        // one extra tick absorbs the phase of the free-running tick
        if (fcnt_r[i] == ((i < WW) ? lim_slow : lim_fast)) begin
          filt_nxt[i] = raw[i];
          fcnt_nxt[i] = '0;
        end else begin
          fcnt_nxt[i] = fcnt_r[i] + 12'h001;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r <= '0;
      filt_r <= '0;
      for (int i = 0; i < NF; i++) begin
        fcnt_r[i] <= '0;
      end
    end else begin
      tick_r <= tick_nxt;
      filt_r <= filt_nxt;
      fcnt_r <= fcnt_nxt;
    end
  end

  // special pins bypass the filter so short pulses are not lost
  logic [NP-1:0] prev_r, rise, irq_r, irq_nxt, qr_r, qr_nxt, qr_clr;
  logic [15:0] cnt_r [NP];
  logic [15:0] cnt_nxt [NP];
  plc_cond_pkg::pin_mode_t mode [NP];
  assign rise = pin_raw & ~prev_r;
  always_comb begin
    irq_nxt = '0;
    qr_nxt = qr_r & ~qr_clr;
    for (int j = 0; j < NP; j++) begin
      mode[j] = plc_cond_pkg::pin_mode_t'(
        ctrl_r[plc_cond_pkg::CTRL_MODE_LO + 2 * j +: 2]);
      cnt_nxt[j] = cnt_r[j];
      if (mode[j] != plc_cond_pkg::MODE_CNT || !pin_act[j]) begin
        cnt_nxt[j] = '0;
      end
      if (pin_act[j] && rise[j]) begin
        case (mode[j])
          plc_cond_pkg::MODE_INT: irq_nxt[j] = 1'b1;
          plc_cond_pkg::MODE_CNT: begin
            // zero set value fires on every pulse
            if (set_r[j] == 16'h0000
                || cnt_r[j] + 16'h0001 == set_r[j]) begin
              irq_nxt[j] = 1'b1;
              cnt_nxt[j] = '0;
            end else begin
              cnt_nxt[j] = cnt_r[j] + 16'h0001;
            end
          end
          plc_cond_pkg::MODE_QR: qr_nxt[j] = 1'b1;
          default: ;
        endcase
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= '0;
      irq_r <= '0;
      qr_r <= '0;
      for (int j = 0; j < NP; j++) begin
        cnt_r[j] <= '0;
      end
    end else begin
      prev_r <= pin_raw;
      irq_r <= irq_nxt;
      qr_r <= qr_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  assign int_req = irq_r;

  // knob words refresh continuously
  logic [15:0] knob0_r, knob1_r, knob0_nxt, knob1_nxt;
  always_comb begin
    knob0_nxt = plc_cond_pkg::to_bcd(acc_r[NF +: KW]);
    knob1_nxt = plc_cond_pkg::to_bcd(acc_r[NF + KW +: KW]);
  end

  // status masks active special pins; plain pins and pins absent from the unit show filtered levels
  logic [WW-1:0] spec_mask, stat_w0;
  always_comb begin
    spec_mask = '0;
    for (int j = 0; j < NP; j++) begin
      spec_mask[plc_cond_pkg::PIN_LO + j] =
        pin_act[j] && mode[j] != plc_cond_pkg::MODE_PLAIN;
    end
    stat_w0 = filt_r[WW-1:0] & ~spec_mask;
  end

  // apb slave: read data caught in setup, zero-wait access phase
  logic [9:0] idx;
  logic [31:0] rd, prdata_r, prdata_nxt;
  logic hit, acc_ph;
  assign idx = paddr[11:2];
  assign acc_ph = psel && penable;
  always_comb begin
    rd = 32'h0000_0000;
    hit = (paddr[1:0] == 2'h0);
    case (idx)
      plc_cond_pkg::IDX_CTRL: rd = {16'h0000, ctrl_r};
      plc_cond_pkg::IDX_IN0: rd = {20'h00000, stat_w0};
      plc_cond_pkg::IDX_IN1: rd = {20'h00000, filt_r[NF-1:WW]};
      plc_cond_pkg::IDX_QR: rd = {28'h0000000, qr_r};
      plc_cond_pkg::IDX_SET0, plc_cond_pkg::IDX_SET1,
      plc_cond_pkg::IDX_SET2, plc_cond_pkg::IDX_SET3:
        rd = {16'h0000, set_r[idx[1:0]]};
      plc_cond_pkg::IDX_KNOB0: rd = {16'h0000, knob0_r};
      plc_cond_pkg::IDX_KNOB1: rd = {16'h0000, knob1_r};
      default: hit = 1'b0;
    endcase
    prdata_nxt = prdata_r;
    if (psel && !penable && !pwrite) begin
      prdata_nxt = hit ? rd : 32'h0000_0000;
    end
    // only bits reported to software are cleared; new pulses survive
    qr_clr = '0;
    if (acc_ph && !pwrite && hit && idx == plc_cond_pkg::IDX_QR) begin
      qr_clr = prdata_r[NP-1:0];
    end
    ctrl_nxt = ctrl_r;
    set_nxt = set_r;
    if (acc_ph && pwrite && hit) begin
      if (idx == plc_cond_pkg::IDX_CTRL) begin
        ctrl_nxt = pwdata[15:0] & plc_cond_pkg::CTRL_MASK;
      end
      if (idx[9:2] == plc_cond_pkg::IDX_SET0[9:2]) begin
        set_nxt[idx[1:0]] = pwdata[15:0];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= plc_cond_pkg::CTRL_RST;
      prdata_r <= '0;
      knob0_r <= '0;
      knob1_r <= '0;
      for (int j = 0; j < NP; j++) begin
        set_r[j] <= '0;
      end
    end else begin
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
      knob0_r <= knob0_nxt;
      knob1_r <= knob1_nxt;
      set_r <= set_nxt;
    end
  end
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = acc_ph && !hit;

  // helper: cycles that raw bit 0 of words 000 and 001 has held its level
  logic [31:0] stab_r, stab1_r;
  logic raw0_prev_r, raw1_prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_r <= '0;
      stab1_r <= '0;
      raw0_prev_r <= 1'b0;
      raw1_prev_r <= 1'b0;
    end else begin
      raw0_prev_r <= raw[0];
      raw1_prev_r <= raw[WW];
      stab_r <= (raw[0] != raw0_prev_r) ? 32'h0 : stab_r + 32'h1;
      stab1_r <= (raw[WW] != raw1_prev_r) ? 32'h0 : stab1_r + 32'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_knob_range: assert property (knob0_r[15:8] <= 8'h02
    && knob0_r[7:4] <= 4'h9 && knob0_r[3:0] <= 4'h9)
    else $error("knob word out of bcd range");
  a_knob_word: assert property (acc_ph && !pwrite
    && idx == plc_cond_pkg::IDX_KNOB1 |-> prdata == $past(knob1_r))
    else $error("knob one read mismatch");
  a_filter_window: assert property ($changed(filt_r[0])
    |-> stab_r + 32'h3 >= 32'(lim_slow) * 32'(TICK_CYCLES)
    && stab_r <= (32'(lim_slow) + 32'h1) * 32'(TICK_CYCLES) + 32'h3)
    else $error("word 000 filter delay outside window");
  a_filter_tick: assert property ($changed(filt_r) |-> $past(tick))
    else $error("filter output moved off tick");
  a_fast_shorter: assert property ($changed(filt_r[WW])
    |-> stab1_r < 32'(lim_slow) * 32'(TICK_CYCLES))
    else $error("later word filter not faster than setting");
  a_int_prompt: assert property (pin_act[0] && rise[0]
    && mode[0] == plc_cond_pkg::MODE_INT |=> int_req[0])
    else $error("interrupt request missing");
  a_cnt_restart: assert property (pin_act[1] && rise[1]
    && mode[1] == plc_cond_pkg::MODE_CNT
    && cnt_r[1] + 16'h0001 == set_r[1] |=> int_req[1] && cnt_r[1] == 0)
    else $error("counter did not fire and restart");
  a_req_cause: assert property (int_req[0] |-> $past(rise[0]))
    else $error("request without input edge");
  a_pins_small: assert property (!$past(wide)
    |-> int_req[3:2] == 2'h0)
    else $error("request on pin absent in small unit");
  a_quick_hold: assert property ((~qr_r & $past(qr_r)
    & ~$past(qr_clr)) == 4'h0)
    else $error("quick latch lost before read");
  a_plain_pin: assert property ($past(mode[0])
    == plc_cond_pkg::MODE_PLAIN |-> !int_req[0])
    else $error("plain pin raised request");

  c_int: cover property (int_req[0] ##1 !int_req[0]);
  c_cnt: cover property (mode[1] == plc_cond_pkg::MODE_CNT && int_req[1]);
  c_qr: cover property (qr_clr != 0);
  c_filt: cover property ($rose(filt_r[0]));
endmodule : plc_input_conditioning

//--- plc_field_src.sv
// field switches, sensors, knobs and pulse sources at the terminals
module plc_field_src (
  input wire logic clk, // bench clock, levels move just after its edge
  output logic [11:0] w0, // terminals of word 000
  output logic [11:0] w1, // terminals of word 001
  output logic [7:0] knob0, // knob zero position
  output logic [7:0] knob1 // knob one position
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    w0 = 12'h000;
    w1 = 12'h000;
    knob0 = 8'h00;
    knob1 = 8'h00;
  end
  task automatic set_pin(input int w, input int b, input logic v);
    @(posedge clk);
    if (w == 0) w0[b] <= v;
    else w1[b] <= v;
  endtask : set_pin
  // hi cycles high then lo at rest; one caller keeps the width below the filter time to see it rejected
  task automatic pulse(input int b, input int hi, input int lo);
    set_pin(0, b, 1'b1);
    repeat (hi - 1) @(posedge clk);
    set_pin(0, b, 1'b0);
    repeat (lo - 1) @(posedge clk);
  endtask : pulse
  task automatic set_knobs(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    knob0 <= a;
    knob1 <= b;
  endtask : set_knobs
endmodule : plc_field_src

//--- plc_input_conditioning_tb_top.sv
// self-checking bench for the input conditioning block
module plc_input_conditioning_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] k0; logic [7:0] k1; logic [15:0] e0; logic [15:0] e1;
  } knob_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wide_unit, err;
  logic [11:0] paddr, in_w0, in_w1;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] knob0_raw, knob1_raw;
  logic [3:0] int_req;
  int error_cnt, num_checks;
  int icnt[4];
  knob_row_t rows[4] = '{'{8'h00, 8'hC8, 16'h0000, 16'h0200},
    '{8'h63, 8'h7B, 16'h0099, 16'h0123}, '{8'hFF, 8'h07, 16'h0200, 16'h0007},
    '{8'h96, 8'hC9, 16'h0150, 16'h0200}};
  plc_input_conditioning #(.TICK_CYCLES(10)) i_plc_input_conditioning (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_w0(in_w0), .in_w1(in_w1),
    .knob0_raw(knob0_raw), .knob1_raw(knob1_raw), .wide_unit(wide_unit),
    .int_req(int_req));
  plc_field_src i_plc_field_src (.clk(pclk), .w0(in_w0), .w1(in_w1),
    .knob0(knob0_raw), .knob1(knob1_raw));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // width of each request counts, so a stretched pulse shows up as 2
  always @(posedge pclk) begin
    for (int k = 0; k < 4; k++) if (int_req[k] === 1'b1) icnt[k]++;
  end
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  // toggle terminal 0 of a word; old level just before lo, new one by hi
  task automatic filt(input int w, input logic [2:0] sel, input int lo,
                      input int hi);
    logic old;
    old = (w == 0) ? in_w0[0] : in_w1[0];
    apb(1'b1, 12'h000, {29'h0, sel});
    i_plc_field_src.set_pin(w, 0, ~old);
    repeat (lo - 4) @(posedge pclk);
    rdchk((w == 0) ? 12'h004 : 12'h008, {31'h0, old});
    repeat (hi - lo) @(posedge pclk);
    rdchk((w == 0) ? 12'h004 : 12'h008, {31'h0, ~old});
  endtask : filt
  // each pulse leaves 60 cycles (3 us) after its rise for the request
  // requests are only counted; no forced refresh ever follows them
  task automatic ints(input int b, input int n, input int ep);
    icnt[b - 3] = 0;
    repeat (n) i_plc_field_src.pulse(b, 10, 50);
    chk(32'(icnt[b - 3]), 32'(ep));
  endtask : ints
  initial begin
    #2000000;
    error_cnt++;
    conclude;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, rd, err} = '0;
    wide_unit = 1'b1;
    error_cnt = 0;
    num_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({28'h0, int_req}, 32'h0);
    rdchk(12'h000, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h3E9, 32'h0);
    chk({31'h0, err}, 32'h1);
    foreach (rows[i]) begin
      i_plc_field_src.set_knobs(rows[i].k0, rows[i].k1);
      repeat (8) @(posedge pclk);
      rdchk(12'h3E8, {16'h0, rows[i].e0});
      rdchk(12'h3EC, {16'h0, rows[i].e1});
    end
    filt(0, 3'h0, 200, 300);
    filt(0, 3'h2, 800, 900);
    filt(0, 3'h1, 400, 500);
    filt(0, 3'h3, 1600, 1700);
    filt(1, 3'h3, 600, 900);
    filt(1, 3'h0, 20, 60);
    filt(1, 3'h7, 10000, 14000);
    apb(1'b1, 12'h000, 32'h0);
    i_plc_field_src.set_pin(0, 3, 1'b1);
    i_plc_field_src.pulse(1, 150, 310);
    rdchk(12'h004, 32'h8);
    i_plc_field_src.set_pin(0, 3, 1'b0);
    apb(1'b1, 12'h000, 32'h0100);
    ints(3, 1, 1);
    ints(3, 2, 2);
    apb(1'b1, 12'h000, 32'h0800);
    apb(1'b1, 12'h014, 32'h3);
    ints(4, 7, 2);
    apb(1'b1, 12'h014, 32'h0);
    ints(4, 2, 2);
    wide_unit <= 1'b0;
    apb(1'b1, 12'h000, 32'h1000);
    ints(5, 1, 0);
    wide_unit <= 1'b1;
    ints(5, 1, 1);
    apb(1'b1, 12'h000, 32'hC000);
    i_plc_field_src.pulse(6, 4, 300);
    rdchk(12'h00C, 32'h8);
    rdchk(12'h00C, 32'h0);
    conclude;
  end
endmodule : plc_input_conditioning_tb_top
